/* File: hw/txla_alert_flags.sv */
// Transmit and link safety alert flag bank with an Avalon-MM slave.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module txla_alert_flags
#(
   parameter int PTR_W = 3,   // Width of the queue pointers.
   parameter int STAT_W = 8   // Width of the fault packet status vector.
)
(
   input wire logic mclk,                         // System clock, 40 MHz.
   input wire logic reset_n,                      // Asynchronous reset, active low.
   input wire logic [7:0] address,                // Avalon byte address.
   input wire logic read,                         // Avalon read request.
   input wire logic write,                        // Avalon write request.
   input wire logic [31:0] writedata,             // Avalon write data.
   input wire logic [3:0] byteenable,             // Avalon byte enables.
   output logic [31:0] readdata,                  // Avalon read data, registered.
   output logic waitrequest,                      // Avalon wait request.
   input wire logic [PTR_W-1:0] load_queue_pointer, // Queue being loaded.
   input wire logic [PTR_W-1:0] xmit_queue_pointer, // Queue being transmitted.
   input wire logic rx_frame_end,                 // Pulse: message end (stop, preamble, timeout).
   input wire logic rx_buffer_empty,              // Receive buffer holds no unread data.
   input wire logic rx_from_fault_poll,           // Current message came from a fault_poll_packet.
   input wire logic rx_all_read,                  // Pulse: host has read all unread messages.
   input wire logic status_arrive,                // Pulse: status bits arrive in packet buffer.
   input wire logic [STAT_W-1:0] status_bits,     // Received fault packet status bits.
   input wire logic status_debounced,             // Pulse: pending status debounced.
   input wire logic link_corrupt_evt,             // Pulse: corrupted, inserted or omitted data.
   input wire logic fault_packet_link_error,      // Pulse: fault packet link error.
   input wire logic fault_packet_hardware_error,  // Pulse: fault packet hardware error.
   input wire logic lockstep_checker_mismatch,    // Pulse: echo differs from sent data.
   input wire logic sleep_enable,                 // Sleep mode entered.
   input wire logic safe_watch_entered_flag,      // Safe monitoring mode entered.
   input wire logic heartbeat_err_evt,            // Pulse: heartbeat counter error.
   input wire logic hw_fault_evt,                 // Pulse: hardware fault.
   output logic [7:0] transmit_alert_flags,       // Transmit alert register, registered.
   output logic [7:0] link_safety_alert_byte      // Link safety alert byte, registered.
);
   import txla_pkg::*;

   // =====================================================================
   // Bus decode.
   // Every transfer takes two cycles. In the first cycle the request is taken and
   // waitrequest stands high, and the read data are captured at the edge that ends it. In
   // the second cycle waitrequest is low. A write lands at the edge that ends the second
   // cycle, so the master must hold address, direction and data until that edge.
   // Only byte lane zero carries register data; the upper lanes read as zero.
   logic [7:0] tx_ff;                 // Transmit alert flags.
   logic [7:0] lk_ff;                 // Link safety alert flags.
   logic [STAT_W-1:0] smask_ff;       // Status-error mask, 1 masks a bit.
   logic [STAT_W-1:0] dmask_ff;       // Debounce mask, 1 masks a bit.
   logic [31:0] readdata_ff;          // Registered read data.
   logic ack_ff;                      // One-cycle answer phase.
   logic [31:0] nxt_readdata;         // Next read data.
   wire req = (read | write) & ~ack_ff;   // New request awaiting answer.
   wire wr_go = write & ack_ff;           // Write takes effect at the answer edge.
   wire lane0 = byteenable[0];            // Only the low byte lane holds data.
   wire wr_tx = wr_go & lane0 & (address == TXLA_OFS_TX_ALERT);
   wire wr_lk = wr_go & lane0 & (address == TXLA_OFS_LINK_ALERT);
   wire wr_sm = wr_go & lane0 & (address == TXLA_OFS_STAT_MASK);
   wire wr_dm = wr_go & lane0 & (address == TXLA_OFS_DBNC_MASK);
   wire [7:0] wbyte = writedata[7:0];     // Write byte; zeros clear flags.

   // Zero-extends a byte into a bus word.
   function automatic logic [31:0] widen(input logic [7:0] b);
      widen = {24'h000000, b};
   endfunction

   // Read multiplexer.
   always_comb
   begin
      case (address)
         TXLA_OFS_TX_ALERT: nxt_readdata = widen(tx_ff);
         TXLA_OFS_LINK_ALERT: nxt_readdata = widen(lk_ff);
         TXLA_OFS_STAT_MASK: nxt_readdata = widen(8'(smask_ff));
         TXLA_OFS_DBNC_MASK: nxt_readdata = widen(8'(dmask_ff));
         default: nxt_readdata = TXLA_UNMAPPED;
      endcase
   end

   assign waitrequest = (read | write) & ~ack_ff;
   assign readdata = readdata_ff;
   assign transmit_alert_flags = tx_ff;
   assign link_safety_alert_byte = lk_ff;

   // Answer phase: one wait cycle, then the request completes.
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_ff <= 1'b0;
         readdata_ff <= TXLA_UNMAPPED;
      end
      else
      begin
         ack_ff <= req;
         if (req && read)
         begin
            readdata_ff <= nxt_readdata;
         end
      end
   end

   // =====================================================================
   // Transmit queue conditions.
   // The pointers wrap, so the queue before the transmit queue is found by a subtraction
   // cut back to the pointer width. Full and free are exact opposites of each other,
   // while all-clear is a separate compare of the two pointers.
   wire [PTR_W-1:0] tx_minus1 = PTR_W'(xmit_queue_pointer - 1'b1);
   wire full_c = (load_queue_pointer == tx_minus1);
   wire avail_c = ~full_c;
   wire empty_c = (load_queue_pointer == xmit_queue_pointer);

   // Sticky flag update: a set wins over a write-zero clear.
   function automatic logic flag(input logic cur, input logic set, input logic clr);
      flag = set | (cur & ~clr);
   endfunction

   // Mask selection by operating mode.
   // In host-driven mode the status-error mask applies; in sleep or safe watch the
   // debounce mask applies instead, and a debounced status clears the error by itself.
   wire cmd_mode = ~(sleep_enable | safe_watch_entered_flag);
   wire [STAT_W-1:0] use_mask = cmd_mode ? smask_ff : dmask_ff;
   wire stat_set = status_arrive & (|(status_bits & ~use_mask));
   wire stat_auto = ~cmd_mode & status_debounced;
   wire rx_set = rx_frame_end & ~rx_buffer_empty & ~rx_from_fault_poll;
   wire pkt_set = fault_packet_link_error | fault_packet_hardware_error;
   wire [7:0] tx_clr = wr_tx ? ~wbyte : 8'h00;
   wire [7:0] lk_clr = wr_lk ? ~wbyte : 8'h00;
   // =====================================================================
   // Condition edge detection.
   // The queue conditions and the host-driven mode are levels, yet their flags are event
   // driven: a flag sets only in the cycle in which its condition becomes true. This keeps
   // a write of zero effective while the condition persists; a level set would set the
   // flag again at the very next edge and software could never acknowledge it.
   // The previous-value registers reset to zero, so a condition that already holds when
   // reset is released counts as a fresh event and its flag sets one edge later.
   logic full_prev_ff;    // Full condition in the previous cycle.
   logic avail_prev_ff;   // Free condition in the previous cycle.
   logic empty_prev_ff;   // All-clear condition in the previous cycle.
   logic cmd_prev_ff;     // Host-driven mode in the previous cycle.
   wire full_rise = full_c & ~full_prev_ff;
   wire avail_rise = avail_c & ~avail_prev_ff;
   wire empty_rise = empty_c & ~empty_prev_ff;
   wire cmd_rise = cmd_mode & ~cmd_prev_ff;

   // Remembers each condition for one cycle so that its rise can be seen.
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         full_prev_ff <= 1'b0;
         avail_prev_ff <= 1'b0;
         empty_prev_ff <= 1'b0;
         cmd_prev_ff <= 1'b0;
      end
      else
      begin
         full_prev_ff <= full_c;
         avail_prev_ff <= avail_c;
         empty_prev_ff <= empty_c;
         cmd_prev_ff <= cmd_mode;
      end
   end

   logic [7:0] nxt_tx;   // Next transmit flags.
   logic [7:0] nxt_lk;   // Next link flags.

   // Next flag values; unused transmit bits read as zero.
   // Each flag sets on its event and holds until a write of zero or an automatic clear.
   // When an event and a clear fall in one cycle the event wins, so no event is lost.
   always_comb
   begin
      nxt_tx = TXLA_RESET_BYTE;
      nxt_lk = TXLA_RESET_BYTE;
      nxt_tx[TXLA_B_FULL] = flag(tx_ff[TXLA_B_FULL], full_rise, tx_clr[TXLA_B_FULL]);
      nxt_tx[TXLA_B_AVAIL] = flag(tx_ff[TXLA_B_AVAIL], avail_rise, tx_clr[TXLA_B_AVAIL]);
      nxt_tx[TXLA_B_EMPTY] = flag(tx_ff[TXLA_B_EMPTY], empty_rise, tx_clr[TXLA_B_EMPTY]);
      nxt_lk[TXLA_B_RXRDY] = flag(lk_ff[TXLA_B_RXRDY], rx_set,
                                  lk_clr[TXLA_B_RXRDY] | rx_all_read);
      nxt_lk[TXLA_B_STAT] = flag(lk_ff[TXLA_B_STAT], stat_set,
                                 lk_clr[TXLA_B_STAT] | stat_auto);
      nxt_lk[TXLA_B_COMM] = flag(lk_ff[TXLA_B_COMM], link_corrupt_evt, lk_clr[TXLA_B_COMM]);
      nxt_lk[TXLA_B_PKTERR] = flag(lk_ff[TXLA_B_PKTERR], pkt_set, lk_clr[TXLA_B_PKTERR]);
      nxt_lk[TXLA_B_MSMTCH] = flag(lk_ff[TXLA_B_MSMTCH], lockstep_checker_mismatch,
                                   lk_clr[TXLA_B_MSMTCH]);
      nxt_lk[TXLA_B_CMDOP] = flag(lk_ff[TXLA_B_CMDOP], cmd_rise, lk_clr[TXLA_B_CMDOP]);
      nxt_lk[TXLA_B_ALIVE] = flag(lk_ff[TXLA_B_ALIVE], heartbeat_err_evt, lk_clr[TXLA_B_ALIVE]);
      nxt_lk[TXLA_B_HWERR] = flag(lk_ff[TXLA_B_HWERR], hw_fault_evt, lk_clr[TXLA_B_HWERR]);
   end

   // Flag and mask registers.
   // The masks are plain read-write registers; a one in a mask bit hides that status bit.
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_ff <= TXLA_RESET_BYTE;
         lk_ff <= TXLA_RESET_BYTE;
         smask_ff <= '0;
         dmask_ff <= '0;
      end
      else
      begin
         tx_ff <= nxt_tx;
         lk_ff <= nxt_lk;
         if (wr_sm)
         begin
            smask_ff <= wbyte[STAT_W-1:0];
         end
         if (wr_dm)
         begin
            dmask_ff <= wbyte[STAT_W-1:0];
         end
      end
   end

   // =====================================================================
   // Assertions.
   // All checks run on the system clock and are switched off while reset is applied.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_clear_write;
      wr_lk && !wbyte[TXLA_B_COMM] && !link_corrupt_evt;
   endsequence

   a_full_sets: assert property (full_rise |=> tx_ff[TXLA_B_FULL])
      else $error("Occupied flag not set on full queues.");
   a_avail_sets: assert property (avail_rise |=> tx_ff[TXLA_B_AVAIL])
      else $error("Free flag not set while not full.");
   a_empty_sets: assert property (empty_rise |=> tx_ff[TXLA_B_EMPTY])
      else $error("All-clear flag not set on equal pointers.");
   a_write_clears: assert property (s_clear_write |=> !lk_ff[TXLA_B_COMM])
      else $error("Write of zero did not clear flag.");
   a_write_one_keeps: assert property (wr_lk && wbyte[TXLA_B_MSMTCH] && lk_ff[TXLA_B_MSMTCH]
      |=> lk_ff[TXLA_B_MSMTCH])
      else $error("Write of one changed a flag.");
   a_rx_ready_set: assert property (rx_frame_end && !rx_buffer_empty && !rx_from_fault_poll
      |=> lk_ff[TXLA_B_RXRDY])
      else $error("Receive ready not set.");
   a_rx_auto_clr: assert property (rx_all_read && !rx_set |=> !lk_ff[TXLA_B_RXRDY])
      else $error("Receive ready not auto-cleared.");
   a_rx_no_empty: assert property (!lk_ff[TXLA_B_RXRDY] && rx_buffer_empty
      |=> !lk_ff[TXLA_B_RXRDY])
      else $error("Receive ready set on empty buffer.");
   a_rx_no_poll: assert property (!lk_ff[TXLA_B_RXRDY] && rx_from_fault_poll
      |=> !lk_ff[TXLA_B_RXRDY])
      else $error("Receive ready set for a poll packet.");
   a_stat_err: assert property (status_arrive && cmd_mode && |(status_bits & ~smask_ff)
      |=> lk_ff[TXLA_B_STAT])
      else $error("Status error not set in commanded mode.");
   a_stat_dbnc: assert property (!cmd_mode && status_debounced && !stat_set
      |=> !lk_ff[TXLA_B_STAT])
      else $error("Status error not auto-cleared on debounce.");
   a_link_corrupt: assert property (link_corrupt_evt |=> lk_ff[TXLA_B_COMM])
      else $error("Link corruption flag not set.");
   a_pkt_err: assert property (fault_packet_hardware_error |=> lk_ff[TXLA_B_PKTERR])
      else $error("Packet error flag not set.");
   a_mismatch: assert property (lockstep_checker_mismatch |=> lk_ff[TXLA_B_MSMTCH])
      else $error("Echo mismatch flag not set.");
   a_cmd_mode: assert property (!sleep_enable && !safe_watch_entered_flag && !cmd_prev_ff
      |=> lk_ff[TXLA_B_CMDOP])
      else $error("Host-driven mode flag not set.");
   a_flag_holds: assert property (lk_ff[TXLA_B_COMM] && !wr_lk |=> lk_ff[TXLA_B_COMM])
      else $error("Flag dropped without clear.");

   // A software acknowledge: a write of zero to the bit with no new rise in that cycle.
   // It must clear the flag even though the level condition behind it still holds.
   sequence s_full_ack;
      wr_tx && !wbyte[TXLA_B_FULL] && !full_rise;
   endsequence
   sequence s_cmd_ack;
      wr_lk && !wbyte[TXLA_B_CMDOP] && !cmd_rise;
   endsequence
   // A flag that is low and sees no new rise must stay low.
   sequence s_full_quiet;
      !tx_ff[TXLA_B_FULL] && !full_rise;
   endsequence

   a_full_ack: assert property (s_full_ack |=> !tx_ff[TXLA_B_FULL])
      else $error("Occupied flag not cleared while full.");
   a_cmd_ack: assert property (s_cmd_ack |=> !lk_ff[TXLA_B_CMDOP])
      else $error("Host-driven mode flag not cleared.");
   a_empty_ack: assert property (wr_tx && !wbyte[TXLA_B_EMPTY] && !empty_rise
      |=> !tx_ff[TXLA_B_EMPTY])
      else $error("All-clear flag not cleared while pointers equal.");
   a_full_quiet: assert property (s_full_quiet |=> !tx_ff[TXLA_B_FULL])
      else $error("Occupied flag set without a new full condition.");
   a_avail_quiet: assert property (!tx_ff[TXLA_B_AVAIL] && !avail_rise
      |=> !tx_ff[TXLA_B_AVAIL])
      else $error("Free flag set without a new free condition.");
   a_pkt_link: assert property (fault_packet_link_error |=> lk_ff[TXLA_B_PKTERR])
      else $error("Packet error flag not set on link error.");
   a_cmd_low: assert property (!cmd_mode && !lk_ff[TXLA_B_CMDOP]
      |=> !lk_ff[TXLA_B_CMDOP])
      else $error("Host-driven mode flag set outside host mode.");
   a_hw_fault: assert property (hw_fault_evt |=> lk_ff[TXLA_B_HWERR])
      else $error("Hardware fault flag not set.");
endmodule

/* File: include/txla_pkg.sv */
// Package with register offsets, bit positions and reset values for the alert flag bank.
// =====================================================================
// Contract
// - Full flag when load equals transmit minus one.
// - Free flag while full condition false; the code sets it when full goes false and holds it until written zero.
// - All-clear flag when load equals transmit pointer.
// - Write zero clears; write one no effect.
// - Receive ready set on framed message end.
// - Receive ready auto-clears when all read.
// - No receive ready for stop on empty.
// - No receive ready for fault-poll packets.
// - Status error on unmasked status bit arrival.
// - Commanded mode uses status-error mask.
// - Sleep/safe mode uses debounce mask, auto-clears.
// - Link corruption flag on corrupted message data.
// - Packet error on link or hardware error.
// - Echo mismatch flag on lockstep checker mismatch.
// - Host-driven flag is NOT(sleep OR safe-watch); the code sets it when that goes true and holds it until written zero.
package txla_pkg;
   // =====================================================================
   // Register map (byte addresses on the Avalon-MM bus).
   localparam logic [7:0] TXLA_OFS_TX_ALERT = 8'h10;   // Transmit alert flags.
   localparam logic [7:0] TXLA_OFS_LINK_ALERT = 8'h14; // Link safety alert byte.
   localparam logic [7:0] TXLA_OFS_STAT_MASK = 8'h18;  // Status-error mask.
   localparam logic [7:0] TXLA_OFS_DBNC_MASK = 8'h1c;  // Debounce mask.
   localparam logic [7:0] TXLA_RESET_BYTE = 8'h00;     // Reset value of all registers.
   localparam logic [31:0] TXLA_UNMAPPED = 32'h00000000; // Read data of unmapped addresses.
   // =====================================================================
   // Bit positions in the transmit alert register.
   localparam int TXLA_B_EMPTY = 0; // All-clear flag.
   localparam int TXLA_B_AVAIL = 1; // Free flag.
   localparam int TXLA_B_FULL = 2;  // Occupied flag.
   // Bit positions in the link safety alert byte.
   localparam int TXLA_B_HWERR = 0;  // Hardware fault flag.
   localparam int TXLA_B_ALIVE = 1;  // Heartbeat counter error flag.
   localparam int TXLA_B_CMDOP = 2;  // Host-driven mode flag.
   localparam int TXLA_B_MSMTCH = 3; // Echo mismatch flag.
   localparam int TXLA_B_PKTERR = 4; // Fault packet error flag.
   localparam int TXLA_B_COMM = 5;   // Link corruption flag.
   localparam int TXLA_B_STAT = 6;   // Fault packet status error flag.
   localparam int TXLA_B_RXRDY = 7;  // Receive message ready flag.
endpackage

/* File: tb/txla_host_model.sv */
// Host-side Avalon-MM master that reads and clears the alert flags.
`timescale 1ns/1ps
module txla_host_model
(
   input wire logic mclk,              // System clock.
   output logic [7:0] address,         // Byte address.
   output logic read,                  // Read request.
   output logic write,                 // Write request.
   output logic [31:0] writedata,      // Write data.
   output logic [3:0] byteenable,      // Byte enables.
   input wire logic [31:0] readdata,   // Read data.
   input wire logic waitrequest        // Wait request.
);
   // ==========================================================
   // Bus transfer
   initial
   begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'hf;
   end
   // Holds the request until waitrequest is seen low, then takes the data.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge mclk);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= {24'h000000, d};
      do
      begin
         @(posedge mclk);
      end
      while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
endmodule

/* File: tb/txla_alert_flags_tb_top.sv */
// Self-checking testbench for the transmit and link alert flag bank.
`timescale 1ns/1ps
module txla_alert_flags_tb_top;
   import txla_pkg::*;
   // ==========================================================
   // Signals, named as the ports so that the instances connect by name.
   logic mclk = 1'b0, reset_n = 1'b0; // Clock and reset.
   logic [7:0] address, link_safety_alert_byte, transmit_alert_flags; // Bus and mirrors.
   logic read, write, waitrequest; // Bus handshake.
   logic [31:0] writedata, readdata; // Bus data.
   logic [3:0] byteenable; // Byte enables.
   logic [2:0] load_queue_pointer = 3'h0, xmit_queue_pointer = 3'h0; // Queue pointers.
   logic hw_fault_evt = 0, heartbeat_err_evt = 0, fault_packet_hardware_error = 0; // Events.
   logic lockstep_checker_mismatch = 0, fault_packet_link_error = 0, link_corrupt_evt = 0;
   logic rx_frame_end = 0, rx_all_read = 0, status_arrive = 0, status_debounced = 0;
   logic rx_buffer_empty = 0, rx_from_fault_poll = 0, sleep_enable = 0; // Levels.
   logic safe_watch_entered_flag = 0; // Safe watch level.
   logic [7:0] status_bits = 8'h00; // Arriving status bits.
   int fail_count = 0;
   int n_checks = 0;
   localparam logic [7:0] EMAP [7] = '{8'h01, 8'h02, 8'h10, 8'h08, 8'h10, 8'h20, 8'h80};
   txla_alert_flags i_txla_alert_flags (.*);
   txla_host_model i_txla_host_model (.*);
   always #12.5 mclk = ~mclk;
   // ==========================================================
   // Shared checks and bus helpers.
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) $display("[FAIL] %s expected %h seen %h", nm, e, g);
      if (g !== e) fail_count++;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] q;
      i_txla_host_model.xfer(1'b0, a, 8'h00, q);
      chk(nm, e, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      i_txla_host_model.xfer(1'b1, a, d, q);
   endtask
   // One-cycle pulse on the chosen event input.
   task automatic pulse(input int i);
      @(posedge mclk);
      case (i)
         0: hw_fault_evt <= 1; 1: heartbeat_err_evt <= 1; 2: fault_packet_hardware_error <= 1;
         3: lockstep_checker_mismatch <= 1; 4: fault_packet_link_error <= 1;
         5: link_corrupt_evt <= 1; 6: rx_frame_end <= 1; 7: rx_all_read <= 1;
         8: status_arrive <= 1; default: status_debounced <= 1;
      endcase
      @(posedge mclk);
      {hw_fault_evt, heartbeat_err_evt, fault_packet_hardware_error, rx_frame_end} <= 0;
      {lockstep_checker_mismatch, fault_packet_link_error, link_corrupt_evt} <= 0;
      {rx_all_read, status_arrive, status_debounced} <= 0;
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_tx;
      @(posedge mclk);
      load_queue_pointer <= 3'h3;
      xmit_queue_pointer <= 3'h4;
      rd(TXLA_OFS_TX_ALERT, 8'h07, "tx full sticky");
      wr(TXLA_OFS_TX_ALERT, 8'h00);
      rd(TXLA_OFS_TX_ALERT, 8'h00, "tx clear while full");
      load_queue_pointer <= 3'h4;
      rd(TXLA_OFS_TX_ALERT, 8'h03, "tx empty");
      wr(TXLA_OFS_TX_ALERT, 8'h00);
      load_queue_pointer <= 3'h3;
      rd(TXLA_OFS_TX_ALERT, 8'h04, "tx full again");
      load_queue_pointer <= 3'h6;
      rd(TXLA_OFS_TX_ALERT, 8'h06, "tx free");
      $display("test tx flags done");
   endtask
   task automatic t_link;
      for (int i = 0; i < 7; i++)
      begin
         wr(TXLA_OFS_LINK_ALERT, 8'h00);
         pulse(i);
         wr(TXLA_OFS_LINK_ALERT, 8'hff);
         rd(TXLA_OFS_LINK_ALERT, EMAP[i], "event flag");
      end
      pulse(7);
      rd(TXLA_OFS_LINK_ALERT, 8'h00, "rx auto clear");
      rx_buffer_empty <= 1;
      pulse(6);
      rd(TXLA_OFS_LINK_ALERT, 8'h00, "stop on empty");
      rx_buffer_empty <= 0;
      rx_from_fault_poll <= 1;
      pulse(6);
      rd(TXLA_OFS_LINK_ALERT, 8'h00, "poll message");
      rx_from_fault_poll <= 0;
      sleep_enable <= 1;
      wr(TXLA_OFS_LINK_ALERT, 8'h00);
      rd(TXLA_OFS_LINK_ALERT, 8'h00, "sleep mode");
      sleep_enable <= 0;
      safe_watch_entered_flag <= 1;
      wr(TXLA_OFS_LINK_ALERT, 8'h00);
      rd(TXLA_OFS_LINK_ALERT, 8'h00, "safe mode");
      safe_watch_entered_flag <= 0;
      rd(TXLA_OFS_LINK_ALERT, 8'h04, "host mode");
      rd(8'h20, 8'h00, "unmapped");
      $display("test link flags done");
   endtask
   task automatic t_stat;
      wr(TXLA_OFS_STAT_MASK, 8'hfe);
      rd(TXLA_OFS_STAT_MASK, 8'hfe, "mask reg");
      status_bits <= 8'h01;
      pulse(8);
      rd(TXLA_OFS_LINK_ALERT, 8'h44, "unmasked status");
      wr(TXLA_OFS_LINK_ALERT, 8'h00);
      status_bits <= 8'h02;
      pulse(8);
      rd(TXLA_OFS_LINK_ALERT, 8'h00, "masked status");
      sleep_enable <= 1;
      status_bits <= 8'h01;
      wr(TXLA_OFS_DBNC_MASK, 8'hff);
      wr(TXLA_OFS_LINK_ALERT, 8'h00);
      pulse(8);
      rd(TXLA_OFS_LINK_ALERT, 8'h00, "debounce masked");
      wr(TXLA_OFS_DBNC_MASK, 8'h00);
      pulse(8);
      rd(TXLA_OFS_LINK_ALERT, 8'h40, "debounce unmasked");
      pulse(9);
      rd(TXLA_OFS_LINK_ALERT, 8'h00, "debounce clear");
      sleep_enable <= 0;
      $display("test status flags done");
   endtask
   // ==========================================================
   // Verdict, main sequence and watchdog.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge mclk);
      chk("reset link byte", TXLA_RESET_BYTE, link_safety_alert_byte);
      chk("reset tx flags", TXLA_RESET_BYTE, transmit_alert_flags);
      reset_n <= 1'b1;
      t_tx;
      t_link;
      t_stat;
      end_of_test;
   end
   initial
   begin
      #200000;
      fail_count++;
      end_of_test;
   end
endmodule
